// ### core/video_pixel_formatter.sv
// shared video memory arbiter, control registers and colour pipeline
`timescale 1ns/1ns

// Functional notes
// - every read takes both banks, sixteen bits
// - host sees 128K bytes, bank from address
// - b8000 window maps one of four pages
// - display fetch wins, host waits a slot
// - display page changes only in retrace
// - character addresses glyph rom, shifter drives dots
// - mode selector picks the pixel format
// - colour registered before and after palette
// - colour code is intensity red green blue
// - even byte character, odd byte attribute
// - attribute colours with optional blink bit
// - 8x8 glyph in 8 wide cell
// - two colour mode, bit 7 first
// - even byte index bit0, odd byte bit1
// - low-res sixteen colour, upper nibble first
// - medium-res sixteen colour, same nibble format
// - four two-bit pixels per byte
// - index 01 mask, 02 border, 03 mode
// - mask bit forces palette index bit zero
// - border register drives outside active area
// - compat mode and colour ports decoded directly
// - border bits are blue green red intensity
// - mode bits border enable, hires4, col16
module video_pixel_formatter #(
  parameter int GLYPH_CELL_ROWS = video_fmt_pkg::GLYPH_ROWS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [2:0] sys_page,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  output logic dram_rd,
  output logic dram_wr,
  output logic [15:0] dram_addr,
  output logic [1:0] dram_byte_we,
  output logic [7:0] dram_wdata,
  input wire logic [15:0] dram_rdata,
  input wire logic fetch_req,
  input wire logic display_enable,
  input wire logic [13:0] disp_addr,
  input wire logic vretrace,
  input wire logic dot_tick,
  input wire logic [3:0] scan_row,
  input wire logic blink_phase,
  output logic [7:0] glyph_char,
  output logic [3:0] glyph_scan,
  input wire logic [7:0] glyph_row,
  output logic [3:0] colour_code,
  output logic pixel_active
);
  import video_fmt_pkg::*;

  // the glyph shifter is one byte wide and scan_row is four bits
  if (GLYPH_CELL_ROWS < 1 || GLYPH_CELL_ROWS > 16) begin : g_check
    $error("GLYPH_CELL_ROWS must lie in 1..16");
  end

  logic [4:0] indexed_register_index;
  logic [3:0] palette_line_mask;
  logic [3:0] border_colour;
  logic [4:0] pixel_mode_control;
  logic [5:0] compat_mode_select;
  logic [5:0] compat_colour_select;
  logic [3:0] video_page_select;
  logic [1:0] disp_page;
  logic [3:0] palette_entries [16];
  logic wr_index;
  logic wr_data;
  pixel_mode_e pixel_mode;

  // host request and arbitration state
  logic host_pend;
  logic host_we;
  logic [16:0] host_byte;
  logic [7:0] host_wdata;
  logic host_hit;
  logic [16:0] hit_byte;
  logic disp_go;
  logic host_go;
  logic host_slot;
  logic host_slot_d;
  logic host_bank;
  logic host_bank_d;
  logic host_miss;

  // display fetch pipeline
  logic p1_valid;
  logic p1_active;
  logic p2_valid;
  logic p2_active;
  logic p3_valid;
  logic p3_active;
  logic [7:0] cell_attr;
  logic [7:0] cell_lo;
  logic [7:0] first_byte;
  logic [3:0] pre_index;
  logic pre_active;
  logic [3:0] pal_addr;
  logic [3:0] post_colour;
  logic post_active;
  logic [3:0] edge_colour;

  assign wr_index = io_wr && io_addr == PORT_INDEX;
  assign wr_data = io_wr && io_addr == PORT_DATA;

  // index port: write-side latch of the register number
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      indexed_register_index <= REG_RESET[4:0];
    end else if (clk_en && wr_index) begin
      indexed_register_index <= io_wdata[4:0];
    end
  end

  // indexed control registers written through the data port
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      palette_line_mask <= REG_RESET[3:0];
      border_colour <= REG_RESET[3:0];
      pixel_mode_control <= REG_RESET[4:0];
    end else if (clk_en && wr_data) begin
      case (indexed_register_index)
        IDX_PALETTE_MASK: palette_line_mask <= io_wdata[3:0];
        IDX_BORDER: border_colour <= io_wdata[3:0];
        IDX_MODE: pixel_mode_control <= io_wdata[4:0];
        default: ;
      endcase
    end
  end

  // palette ram, one entry per index 10..1f
  for (genvar i = 0; i < 16; i++) begin : g_palette
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        palette_entries[i] <= COLOUR_BLACK;
      end else if (clk_en && wr_data &&
                   indexed_register_index[IDX_PALETTE_SEL] &&
                   indexed_register_index[3:0] == 4'(i)) begin
        palette_entries[i] <= io_wdata[3:0];
      end
    end
  end

  // directly decoded compatibility registers and page register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      compat_mode_select <= REG_RESET[5:0];
      compat_colour_select <= REG_RESET[5:0];
      video_page_select <= REG_RESET[3:0];
    end else if (clk_en && io_wr) begin
      case (io_addr)
        PORT_COMPAT_MODE: compat_mode_select <= io_wdata[5:0];
        PORT_COMPAT_COLOUR: compat_colour_select <= io_wdata[5:0];
        PORT_PAGE: video_page_select <= io_wdata[3:0];
        default: ;
      endcase
    end
  end

  // the scanned page only follows the request during retrace, so a
  // frame never mixes two pages
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      disp_page <= 2'b00;
    end else if (clk_en && vretrace) begin
      disp_page <= video_page_select[PG_DISP_LSB +: 2];
    end
  end

  // status answer at the index port, everything else reads zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= REG_RESET;
      io_rvalid <= 1'b0;
    end else if (clk_en) begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        io_rdata <= REG_RESET;
        if (io_addr == PORT_INDEX) begin
          io_rdata[ST_INACTIVE] <= !display_enable;
          io_rdata[ST_VRETRACE] <= vretrace;
        end
      end
    end
  end

  // pixel format from the compatibility and mode control bits
  always_comb begin
    if (!compat_mode_select[CM_GRAPHICS]) begin
      pixel_mode = PM_TEXT;
    end else if (pixel_mode_control[MC_COL16]) begin
      pixel_mode = PM_COL16;
    end else if (pixel_mode_control[MC_HIRES4]) begin
      pixel_mode = PM_HIRES4;
    end else if (compat_mode_select[CM_640]) begin
      pixel_mode = PM_MONO2;
    end else begin
      pixel_mode = PM_MED4;
    end
  end

  // host decode: own 128K region or the paged 32K window
  always_comb begin
    host_hit = 1'b0;
    hit_byte = mem_addr[16:0];
    if (mem_addr[19:17] == sys_page) begin
      host_hit = 1'b1;
    end else if (mem_addr[19:15] == WINDOW_TAG) begin
      host_hit = 1'b1;
      hit_byte = {video_page_select[PG_HOST_LSB +: 2], mem_addr[14:0]};
    end
  end

  // a fetch owns the slot; the host only gets slots the display
  // leaves free, so host traffic never delays a fetch
  assign disp_go = fetch_req && display_enable;
  assign host_go = host_pend && !disp_go;

  // hold one host request until a free slot comes up
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      host_pend <= 1'b0;
      host_we <= 1'b0;
      host_byte <= '0;
      host_wdata <= REG_RESET;
      host_miss <= 1'b0;
    end else if (clk_en) begin
      host_miss <= mem_req && !host_pend && !host_hit;
      if (host_go) begin
        host_pend <= 1'b0;
      end else if (mem_req && !host_pend && host_hit) begin
        host_pend <= 1'b1;
        host_we <= mem_we;
        host_byte <= hit_byte;
        host_wdata <= mem_wdata;
      end
    end
  end

  // dram command registers, one access per clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dram_rd <= 1'b0;
      dram_wr <= 1'b0;
      dram_addr <= '0;
      dram_byte_we <= 2'b00;
      dram_wdata <= REG_RESET;
      host_slot <= 1'b0;
      host_bank <= 1'b0;
    end else if (clk_en) begin
      dram_rd <= disp_go || (host_go && !host_we);
      dram_wr <= host_go && host_we;
      dram_byte_we <= 2'b00;
      host_slot <= host_go;
      if (disp_go) begin
        dram_addr <= {disp_page, disp_addr};
      end else if (host_go) begin
        dram_addr <= host_byte[16:1];
        host_bank <= host_byte[0];
        dram_wdata <= host_wdata;
        if (host_we) begin
          dram_byte_we <= host_byte[0] ? 2'b10 : 2'b01;
        end
      end
    end
  end

  // host answer: read data arrives one cycle after the command
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      host_slot_d <= 1'b0;
      host_bank_d <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= REG_RESET;
    end else if (clk_en) begin
      host_slot_d <= host_slot;
      host_bank_d <= host_bank;
      mem_ack <= host_slot_d || host_miss;
      if (host_slot_d) begin
        // both banks were read; only the addressed byte goes back
        mem_rdata <= host_bank_d ? dram_rdata[15:8] : dram_rdata[7:0];
      end else if (host_miss) begin
        mem_rdata <= UNMAPPED_DATA;
      end
    end
  end

  // fetch pipeline: command, data, glyph lookup, load
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      p1_valid <= 1'b0;
      p1_active <= 1'b0;
      p2_valid <= 1'b0;
      p2_active <= 1'b0;
      p3_valid <= 1'b0;
      p3_active <= 1'b0;
    end else if (clk_en) begin
      p1_valid <= fetch_req;
      p1_active <= disp_go;
      p2_valid <= p1_valid;
      p2_active <= p1_active;
      p3_valid <= p2_valid;
      p3_active <= p2_active;
    end
  end

  // latch the 16-bit cell and present the character to the rom
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cell_lo <= REG_RESET;
      cell_attr <= REG_RESET;
      glyph_char <= REG_RESET;
      glyph_scan <= 4'h0;
    end else if (clk_en && p2_valid) begin
      cell_lo <= p2_active ? dram_rdata[7:0] : REG_RESET;
      cell_attr <= p2_active ? dram_rdata[15:8] : REG_RESET;
      glyph_char <= dram_rdata[7:0];
      glyph_scan <= scan_row;
    end
  end

  // rows past the glyph slot stay blank in the taller text cell
  always_comb begin
    first_byte = cell_lo;
    if (pixel_mode == PM_TEXT) begin
      first_byte = (32'(glyph_scan) < GLYPH_CELL_ROWS) ?
                   glyph_row : REG_RESET;
    end
  end

  pixel_unpacker u_unpack (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .load(p3_valid),
    .mode(pixel_mode),
    .first_byte(first_byte),
    .second_byte(cell_attr),
    .active_in(p3_active),
    .blink_sel(compat_mode_select[CM_BLINK]),
    .blink_phase(blink_phase),
    .extra_bits(compat_colour_select[3:0]),
    .dot_tick(dot_tick),
    .index(pre_index),
    .active(pre_active)
  );

  // masked bits clear their palette address line
  assign pal_addr = pre_index & ~palette_line_mask;

  // second colour register, after the palette
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      post_colour <= COLOUR_BLACK;
      post_active <= 1'b0;
    end else if (clk_en && dot_tick) begin
      post_colour <= palette_entries[pal_addr];
      post_active <= pre_active;
    end
  end

  // border source: indexed register when enabled, else legacy colour
  assign edge_colour = pixel_mode_control[MC_BORDER_EN] ?
                       border_colour : compat_colour_select[3:0];

  // border mux and output register; colour is i,r,g,b from msb
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      colour_code <= COLOUR_BLACK;
      pixel_active <= 1'b0;
    end else if (clk_en && dot_tick) begin
      pixel_active <= post_active;
      if (!compat_mode_select[CM_VIDEO_EN]) begin
        colour_code <= COLOUR_BLACK;
      end else if (post_active) begin
        colour_code <= post_colour;
      end else begin
        colour_code <= edge_colour;
      end
    end
  end

endmodule

// ### core/video_fmt_pkg.sv
// shared constants and types for the video pixel formatter
package video_fmt_pkg;

  // directly decoded i/o ports
  localparam logic [9:0] PORT_COMPAT_MODE = 10'h3d8;
  localparam logic [9:0] PORT_COMPAT_COLOUR = 10'h3d9;
  localparam logic [9:0] PORT_INDEX = 10'h3da;
  localparam logic [9:0] PORT_DATA = 10'h3de;
  localparam logic [9:0] PORT_PAGE = 10'h3df;

  // indexed register numbers behind the index/data pair
  localparam logic [4:0] IDX_PALETTE_MASK = 5'h01;
  localparam logic [4:0] IDX_BORDER = 5'h02;
  localparam logic [4:0] IDX_MODE = 5'h03;
  localparam int IDX_PALETTE_SEL = 4;

  // pixel_mode_control bit positions
  localparam int MC_BORDER_EN = 2;
  localparam int MC_HIRES4 = 3;
  localparam int MC_COL16 = 4;

  // compat_mode_select bit positions
  localparam int CM_GRAPHICS = 1;
  localparam int CM_VIDEO_EN = 3;
  localparam int CM_640 = 4;
  localparam int CM_BLINK = 5;

  // page register fields: display page and host window page
  localparam int PG_DISP_LSB = 0;
  localparam int PG_HOST_LSB = 2;

  // status read at the index port
  localparam int ST_INACTIVE = 0;
  localparam int ST_VRETRACE = 3;

  // host window b8000..bffff decodes on address bits 19:15
  localparam logic [4:0] WINDOW_TAG = 5'h17;
  // glyph rows held by the character rom per cell
  localparam int GLYPH_ROWS = 8;

  // reset values and fixed answers
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] COLOUR_BLACK = 4'h0;
  localparam logic [7:0] UNMAPPED_DATA = 8'hff;

  typedef enum logic [4:0] {
    PM_TEXT = 5'b00001,
    PM_MONO2 = 5'b00010,
    PM_MED4 = 5'b00100,
    PM_HIRES4 = 5'b01000,
    PM_COL16 = 5'b10000
  } pixel_mode_e;

endpackage

// ### core/pixel_unpacker.sv
// per-mode dot shifter that turns a fetched cell into palette indices
`timescale 1ns/1ns
module pixel_unpacker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic load,
  input video_fmt_pkg::pixel_mode_e mode,
  input wire logic [7:0] first_byte,
  input wire logic [7:0] second_byte,
  input wire logic active_in,
  input wire logic blink_sel,
  input wire logic blink_phase,
  input wire logic [3:0] extra_bits,
  input wire logic dot_tick,
  output logic [3:0] index,
  output logic active
);
  import video_fmt_pkg::*;

  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [7:0] attr;
  logic cell_active;
  pixel_mode_e cur_mode;
  logic [3:0] next_index;
  logic [3:0] bg;
  logic fg_on;

  // load a cell, then step the shifter by the mode's pixel width
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sh_a <= REG_RESET;
      sh_b <= REG_RESET;
      attr <= REG_RESET;
      cell_active <= 1'b0;
      cur_mode <= PM_TEXT;
    end else if (clk_en) begin
      if (load) begin
        sh_a <= first_byte;
        sh_b <= second_byte;
        attr <= second_byte;
        cell_active <= active_in;
        cur_mode <= mode;
      end else if (dot_tick) begin
        case (cur_mode)
          PM_TEXT, PM_HIRES4: begin
            sh_a <= {sh_a[6:0], 1'b0};
            sh_b <= {sh_b[6:0], 1'b0};
          end
          PM_MONO2: {sh_a, sh_b} <= {sh_a[6:0], sh_b, 1'b0};
          PM_MED4: {sh_a, sh_b} <= {sh_a[5:0], sh_b, 2'b00};
          PM_COL16: {sh_a, sh_b} <= {sh_a[3:0], sh_b, 4'h0};
          default: ;
        endcase
      end
    end
  end

  // pick the palette index of the dot at the head of the shifter
  always_comb begin
    bg = blink_sel ? {1'b0, attr[6:4]} : attr[7:4];
    // blinking dots fall back to background during the off phase
    fg_on = sh_a[7] && !(blink_sel && attr[7] && blink_phase);
    case (cur_mode)
      PM_TEXT: next_index = fg_on ? attr[3:0] : bg;
      PM_MONO2: next_index = {extra_bits[3:1], sh_a[7]};
      PM_HIRES4: next_index = {extra_bits[3:2], sh_b[7], sh_a[7]};
      PM_MED4: next_index = {extra_bits[3:2], sh_a[7], sh_a[6]};
      PM_COL16: next_index = sh_a[7:4];
      default: next_index = COLOUR_BLACK;
    endcase
  end

  // register the index ahead of the palette lookup
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      index <= COLOUR_BLACK;
      active <= 1'b0;
    end else if (clk_en && dot_tick) begin
      index <= cell_active ? next_index : COLOUR_BLACK;
      active <= cell_active;
    end
  end

endmodule

// ### tb/dram_model.sv
// behavioural shared video dram, two byte banks side by side
`timescale 1ns/1ns
module dram_model (
  input wire logic clock,
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [1:0] byte_we,
  input wire logic [7:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:65535];
  initial rdata = 16'h5a3c;
  // both banks answer each read; an idle bus shows no stale data
  always @(posedge clock) begin
    if (rd) begin
      rdata <= mem[addr];
    end else begin
      rdata <= ~rdata;
    end
  end
  // a write lands only in the enabled bank
  always @(posedge clock) begin
    if (wr && byte_we[0]) begin
      mem[addr][7:0] <= wdata;
    end
    if (wr && byte_we[1]) begin
      mem[addr][15:8] <= wdata;
    end
  end
endmodule

// ### tb/video_fmt_checker.sv
// assertion checker bound to the video pixel formatter ports
`timescale 1ns/1ns
module video_fmt_checker #(
  parameter int GLYPH_CELL_ROWS = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [9:0] io_addr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic [2:0] sys_page,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic dram_rd,
  input wire logic dram_wr,
  input wire logic [1:0] dram_byte_we,
  input wire logic fetch_req,
  input wire logic display_enable,
  input wire logic vretrace,
  input wire logic dot_tick,
  input wire logic [3:0] colour_code
);
  import video_fmt_pkg::*;
  logic pend;
  logic hit;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // one host request in flight until its acknowledge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
    end else if (clk_en) begin
      pend <= mem_ack ? 1'b0 : (pend | mem_req);
    end
  end
  // system region or the fixed window
  assign hit = mem_addr[19:17] == sys_page || mem_addr[19:15] == WINDOW_TAG;
  a_fetch_wins: assert property (
    clk_en && fetch_req && display_enable |=> dram_rd)
    else $error("display fetch not issued next cycle");
  a_one_access: assert property (
    !(dram_rd && dram_wr))
    else $error("read and write in one cycle");
  a_single_bank: assert property (
    dram_wr |-> $onehot(dram_byte_we))
    else $error("host write not to exactly one bank");
  a_miss_answer: assert property (
    clk_en && mem_req && !pend && !hit
      |-> ##2 (mem_ack && mem_rdata == UNMAPPED_DATA))
    else $error("missed access answered wrongly");
  a_hit_latency: assert property (
    clk_en && mem_req && !pend && hit
      |=> !mem_ack [*2] ##[1:60] mem_ack)
    else $error("host access acknowledged out of bounds");
  a_ack_pulse: assert property (
    mem_ack |=> !mem_ack)
    else $error("acknowledge longer than one cycle");
  a_io_answer: assert property (
    clk_en && io_rd |=> io_rvalid)
    else $error("port read not answered");
  a_wo_readback: assert property (
    clk_en && io_rd && io_addr != PORT_INDEX |=> io_rdata == 8'h00)
    else $error("write-only port read back nonzero");
  a_status_bits: assert property (
    clk_en && io_rd && io_addr == PORT_INDEX
      |=> io_rdata[3] == $past(vretrace)
        && io_rdata[0] == !$past(display_enable))
    else $error("status bits wrong");
  a_colour_on_tick: assert property (
    colour_code != $past(colour_code) |-> $past(dot_tick))
    else $error("colour changed without a dot tick");
endmodule
bind video_pixel_formatter video_fmt_checker #(
  .GLYPH_CELL_ROWS(GLYPH_CELL_ROWS)
) i_video_fmt_checker (
  .clock(clock), .rstn(rstn), .clk_en(clk_en), .io_addr(io_addr),
  .io_rd(io_rd), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
  .mem_req(mem_req), .mem_addr(mem_addr), .sys_page(sys_page),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dram_rd(dram_rd),
  .dram_wr(dram_wr), .dram_byte_we(dram_byte_we), .fetch_req(fetch_req),
  .display_enable(display_enable), .vretrace(vretrace),
  .dot_tick(dot_tick), .colour_code(colour_code)
);

// ### tb/tb_top.sv
// self-checking bench for the video pixel formatter
`timescale 1ns/1ns
module tb_top;
  import video_fmt_pkg::*;
  typedef struct {
    logic [7:0] cms, mc, b0, b1;
    logic [3:0] mask, sr;
    logic blink;
    logic [31:0] dots;
    int n;
  } row_s;
  logic clock;
  logic rstn = 1'b0, clk_en = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic mem_req = 1'b0, mem_we = 1'b0, fetch_req = 1'b0, vretrace = 1'b0;
  logic display_enable = 1'b0, dot_tick = 1'b0, blink_phase = 1'b0;
  logic [9:0] io_addr = 10'h000;
  logic [7:0] io_wdata = 8'h00, mem_wdata = 8'h00, got;
  logic [19:0] mem_addr = 20'h00000;
  logic [2:0] sys_page = 3'h0;
  logic [13:0] disp_addr = 14'h0000;
  logic [3:0] scan_row = 4'h0;
  logic io_rvalid, mem_ack, dram_rd, dram_wr, pixel_active;
  logic [7:0] io_rdata, mem_rdata, dram_wdata, glyph_char, glyph_row;
  logic [15:0] dram_addr, dram_rdata, seen_addr;
  logic [1:0] dram_byte_we;
  logic [3:0] glyph_scan, colour_code;
  logic [3:0] col [1:16];
  int fails = 0, n_compared = 0, cycles = 0;
  row_s rows [9];
  video_pixel_formatter i_video_pixel_formatter (
    .clock(clock), .rstn(rstn), .clk_en(clk_en), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .sys_page(sys_page), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .dram_rd(dram_rd), .dram_wr(dram_wr), .dram_addr(dram_addr),
    .dram_byte_we(dram_byte_we), .dram_wdata(dram_wdata),
    .dram_rdata(dram_rdata), .fetch_req(fetch_req),
    .display_enable(display_enable), .disp_addr(disp_addr),
    .vretrace(vretrace), .dot_tick(dot_tick), .scan_row(scan_row),
    .blink_phase(blink_phase), .glyph_char(glyph_char),
    .glyph_scan(glyph_scan), .glyph_row(glyph_row),
    .colour_code(colour_code), .pixel_active(pixel_active)
  );
  dram_model i_dram_model (
    .clock(clock), .rd(dram_rd), .wr(dram_wr), .addr(dram_addr),
    .byte_we(dram_byte_we), .wdata(dram_wdata), .rdata(dram_rdata)
  );
  // glyph rom stand-in: row pattern differs per scan line
  assign glyph_row = glyph_char ^ {glyph_scan, glyph_scan};
  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic io_w(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clock);
    io_wr <= 1'b0;
  endtask
  task automatic idx_w(input logic [4:0] i, input logic [7:0] d);
    io_w(PORT_INDEX, {3'h0, i});
    io_w(PORT_DATA, d);
  endtask
  task automatic io_r(input logic [9:0] a);
    @(posedge clock);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clock);
    io_rd <= 1'b0;
    got = 8'hxx;
    repeat (3) begin
      @(posedge clock);
      if (io_rvalid === 1'b1) got = io_rdata;
    end
  endtask
  // host byte access, optionally with a display fetch in the same cycle as the request
  task automatic mem(input logic we, input logic [19:0] a,
                     input logic [7:0] d, input logic wf);
    @(posedge clock);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_addr <= a;
    mem_wdata <= d;
    fetch_req <= wf;
    display_enable <= 1'b1;
    disp_addr <= 14'h0000;
    @(posedge clock);
    mem_req <= 1'b0;
    fetch_req <= 1'b0;
    got = 8'hxx;
    repeat (40) begin
      @(posedge clock);
      if (mem_ack === 1'b1) got = mem_rdata;
    end
  endtask
  // one cell fetch, then n dot ticks on alternate cycles
  task automatic fetch(input logic [13:0] a, input logic en, input int n);
    @(posedge clock);
    fetch_req <= 1'b1;
    display_enable <= en;
    disp_addr <= a;
    @(posedge clock);
    fetch_req <= 1'b0;
    repeat (4) begin
      @(posedge clock);
      if (dram_rd === 1'b1) seen_addr = dram_addr;
    end
    for (int k = 1; k <= n; k++) begin
      @(posedge clock);
      dot_tick <= 1'b1;
      @(posedge clock);
      dot_tick <= 1'b0;
      #1 col[k] = colour_code;
    end
  endtask
  // main sequence: reset, pixel table, border, host memory, paging
  initial begin
    rows = '{
      '{8'h09, 8'h04, 8'ha5, 8'h9e, 4'h0, 4'h3, 1'b0, 32'he99e9ee9, 8},
      '{8'h29, 8'h04, 8'ha5, 8'h9e, 4'h0, 4'h0, 1'b1, 32'h11111111, 8},
      '{8'h29, 8'h04, 8'ha5, 8'h9e, 4'h0, 4'h0, 1'b0, 32'he1e11e1e, 8},
      '{8'h09, 8'h04, 8'ha5, 8'h9e, 4'h0, 4'h8, 1'b0, 32'h99999999, 8},
      '{8'h1b, 8'h04, 8'hc5, 8'h00, 4'h0, 4'h0, 1'b0, 32'h11000101, 8},
      '{8'h0b, 8'h0c, 8'hf0, 8'hcc, 4'h0, 4'h0, 1'b0, 32'h33112200, 8},
      '{8'h0a, 8'h04, 8'h1b, 8'he4, 4'h0, 4'h0, 1'b0, 32'h01233210, 8},
      '{8'h0a, 8'h14, 8'h7a, 8'h3c, 4'h0, 4'h0, 1'b0, 32'h7a3c0000, 4},
      '{8'h0a, 8'h14, 8'h7a, 8'h3c, 4'h3, 4'h0, 1'b0, 32'h480c0000, 4}};
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    #1;
    check(colour_code, 4'h0);
    check(dram_rd, 1'b0);
    // palette scrambled on purpose so the lookup shows at the pins
    for (int i = 0; i < 16; i++) begin
      idx_w(5'h10 + 5'(i), 8'(i) ^ 8'h06);
    end
    idx_w(IDX_BORDER, 8'h09);
    foreach (rows[r]) begin
      io_w(PORT_COMPAT_MODE, rows[r].cms);
      idx_w(IDX_MODE, rows[r].mc);
      idx_w(IDX_PALETTE_MASK, {4'h0, rows[r].mask});
      scan_row <= rows[r].sr;
      blink_phase <= rows[r].blink;
      i_dram_model.mem[0] = {rows[r].b1, rows[r].b0};
      fetch(14'h0000, 1'b1, 16);
      // dot j leaves the output register on tick j + 2
      for (int j = 1; j <= rows[r].n; j++) begin
        check(col[j + 2], rows[r].dots[35 - 4 * j -: 4] ^ 4'h6);
      end
    end
    idx_w(5'h06, 8'h05);
    fetch(14'h0000, 1'b0, 8);
    check(pixel_active, 1'b0);
    check(colour_code, 4'h9);
    io_w(PORT_COMPAT_COLOUR, 8'h06);
    idx_w(IDX_MODE, 8'h00);
    fetch(14'h0000, 1'b0, 8);
    check(colour_code, 4'h6);
    mem(1'b1, 20'h00005, 8'h5a, 1'b0);
    check(i_dram_model.mem[2][15:8], 8'h5a);
    mem(1'b1, 20'h10004, 8'h33, 1'b0);
    check(i_dram_model.mem[16'h8002][7:0], 8'h33);
    mem(1'b0, 20'h10004, 8'h00, 1'b0);
    check(got, 8'h33);
    mem(1'b0, 20'h00005, 8'h00, 1'b1);
    check(got, 8'h5a);
    mem(1'b1, 20'h08003, 8'hc7, 1'b0);
    io_w(PORT_PAGE, 8'h05);
    mem(1'b0, 20'hb8003, 8'h00, 1'b0);
    check(got, 8'hc7);
    mem(1'b0, 20'h40000, 8'h00, 1'b0);
    check(got, 8'hff);
    fetch(14'h0005, 1'b1, 0);
    check(seen_addr, 16'h0005);
    vretrace <= 1'b1;
    io_w(PORT_PAGE, 8'h05);
    io_r(PORT_INDEX);
    check(got & 8'h09, 8'h08);
    vretrace <= 1'b0;
    io_r(PORT_COMPAT_MODE);
    check(got, 8'h00);
    fetch(14'h0005, 1'b1, 0);
    check(seen_addr, 16'h4005);
    // mid-run reset: page and colour registers must drop back to zero
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    check(colour_code, 4'h0);
    io_w(PORT_COMPAT_MODE, 8'h09);
    fetch(14'h0005, 1'b1, 0);
    check(seen_addr, 16'h0005);
    fetch(14'h0000, 1'b0, 3);
    check(colour_code, 4'h0);
    complete_run();
  end
endmodule
